// >>> rcpi_defs.svh
`ifndef RCPI_DEFS_SVH
`define RCPI_DEFS_SVH

// Register byte offsets on the host register port
`define RCPI_SEL_OFF 12'h100
`define RCPI_DATA_OFF 12'h104

// Select register field positions
`define RCPI_SLOT_LSB 0
`define RCPI_SLOT_MSB 4
`define RCPI_LINK_LSB 8
`define RCPI_LINK_MSB 12
`define RCPI_DIR_BIT 14
`define RCPI_BUSY_BIT 15

// Data register field positions
`define RCPI_CHANNEL_NUMBER_FIELD_LSB 0
`define RCPI_CHANNEL_NUMBER_FIELD_MSB 6
`define RCPI_PROVISION_FLAG_BIT 8
`define RCPI_LB_BIT 9

// Reset values
`define RCPI_SLOT_RST 5'h00
`define RCPI_LINK_RST 5'h00
`define RCPI_DIR_RST 1'h0
`define RCPI_CHANNEL_NUMBER_FIELD_RST 7'h00
`define RCPI_PROVISION_FLAG_RST 1'h0
`define RCPI_LB_RST 1'h0

// Direction encodings of the access direction bit
`define RCPI_DIR_WRITE 1'h0
`define RCPI_DIR_READ 1'h1

// Slot used for every byte of an unchannelised link
`define RCPI_SLOT_UNCH 5'h00

`endif

// >>> rcpi_pkg.sv
package rcpi_pkg;

  // Provision entry: loopback flag, provision flag, channel number
  typedef struct packed {
    logic lb;
    logic provision_flag;
    logic [6:0] channel_number_field;
  } rcpi_entry_s;

  // Indirect access sequencer, one-hot
  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_ACCESS = 3'h2,
    ST_CAPTURE = 3'h4
  } rcpi_state_e;

  // Whole state of the register and sequencer logic
  typedef struct packed {
    rcpi_state_e state;
    logic busy;
    logic dir;
    logic [4:0] link;
    logic [4:0] slot;
    rcpi_entry_s data;
    logic [31:0] rdata;
    logic rack;
  } rcpi_top_s;

  // Whole state of the byte lookup pipeline
  typedef struct packed {
    logic v1;
    logic [7:0] byte1;
    logic v2;
    logic lb2;
    logic [6:0] chan2;
    logic [7:0] byte2;
    logic pop;
    logic [6:0] lb_channel_number_field;
    logic out_valid;
    logic [6:0] out_channel_number_field;
    logic [7:0] out_data;
    logic drop;
  } rcpi_path_s;

endpackage

// >>> rcpi_provision_flag_mem.sv
`timescale 1ns/1ns
`default_nettype none
// Two-port provision memory: port A read/write, port B read only
module rcpi_provision_flag_mem #(
  parameter int AW = 10,
  parameter int DW = 9
) (
  // Clock
  input wire logic clk,
  // Port A, indirect access
  input wire logic a_en,
  input wire logic a_we,
  input wire logic [AW-1:0] a_addr,
  input wire logic [DW-1:0] a_wdata,
  output logic [DW-1:0] a_rdata,
  // Port B, byte lookup
  input wire logic b_en,
  input wire logic [AW-1:0] b_addr,
  output logic [DW-1:0] b_rdata
);

  // Entry storage, no reset: software provisions every used entry
  logic [DW-1:0] mem [0:(1<<AW)-1];

  // Writes and registered reads; a same-address read on B sees old data
  always_ff @(posedge clk) begin
    if (a_en && a_we) begin
      mem[a_addr] <= a_wdata;
    end
    if (a_en && !a_we) begin
      a_rdata <= mem[a_addr];
    end
    if (b_en) begin
      b_rdata <= mem[b_addr];
    end
  end

endmodule
`default_nettype wire

// >>> rcpi_byte_path.sv
`timescale 1ns/1ns
`default_nettype none
`include "rcpi_defs.svh"
// Per-byte lookup: membership and loopback substitution
module rcpi_byte_path
  import rcpi_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Entry from memory port B, one cycle after the request
  input wire rcpi_pkg::rcpi_entry_s entry,
  // Incoming byte, registered alongside the memory read
  input wire logic in_valid,
  input wire logic [7:0] in_data,
  // Loopback FIFO head, valid while pop is high
  input wire logic [7:0] lb_data,
  output logic lb_pop,
  output logic [6:0] lb_channel_number_field,
  // Result
  output logic out_valid,
  output logic [6:0] out_channel_number_field,
  output logic [7:0] out_data,
  output logic out_drop
);

  rcpi_path_s s_r;
  rcpi_path_s s_nxt;

  // Three-stage pipe: address, entry, result
  always_comb begin
    s_nxt = s_r;
    s_nxt.v1 = in_valid;
    s_nxt.byte1 = in_data;
    s_nxt.v2 = s_r.v1 && entry.provision_flag;
    s_nxt.drop = s_r.v1 && !entry.provision_flag;
    s_nxt.chan2 = entry.channel_number_field;
    s_nxt.byte2 = s_r.byte1;
    s_nxt.lb2 = s_r.v1 && entry.provision_flag && entry.lb;
    s_nxt.pop = s_r.v1 && entry.provision_flag && entry.lb;
    s_nxt.lb_channel_number_field = entry.channel_number_field;
    s_nxt.out_valid = s_r.v2;
    s_nxt.out_channel_number_field = s_r.chan2;
    s_nxt.out_data = s_r.lb2 ? lb_data : s_r.byte2;
  end

  // State register, synchronous reset
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign lb_pop = s_r.pop;
  assign lb_channel_number_field = s_r.lb_channel_number_field;
  assign out_valid = s_r.out_valid;
  assign out_channel_number_field = s_r.out_channel_number_field;
  assign out_data = s_r.out_data;
  assign out_drop = s_r.drop;

endmodule
`default_nettype wire

// >>> rcpi_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "rcpi_defs.svh"
module rcpi_top (
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic RST_N,
  // Host register port
  input wire logic [11:0] REG_ADDR,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [31:0] REG_WDATA,
  output logic [31:0] REG_RDATA,
  output logic REG_RACK,
  // Per-link channelise enable
  input wire logic [31:0] CHANNELISE_ENABLE,
  // Received byte stream
  input wire logic RX_VALID,
  input wire logic [4:0] RX_LINK,
  input wire logic [4:0] RX_SLOT,
  input wire logic [7:0] RX_DATA,
  // Loopback FIFO
  input wire logic [7:0] LB_DATA,
  output logic LB_POP,
  output logic [6:0] LB_CHANNEL_NUMBER_FIELD,
  // Channel-assigned output
  output logic OUT_VALID,
  output logic [6:0] OUT_CHANNEL_NUMBER_FIELD,
  output logic [7:0] OUT_DATA,
  output logic OUT_DROP
);
  import rcpi_pkg::*;

  // How software uses this block:
  //   1. Stage channel, provision and loopback in the data register
  //   2. Write the select register with link, slot and direction
  //   3. Poll busy until low, then read the data register
  // Limitation: slot numbers are not range checked; a slot outside
  // the link's frame addresses an entry no byte ever looks up.
  // Limitation: memory contents are not reset; every entry a link
  // uses must be written before bytes arrive on that link.

  // Register state and its next value
  rcpi_top_s s_r;
  rcpi_top_s s_nxt;

  // Memory port A controls
  logic a_en;
  logic a_we;
  logic [9:0] a_addr;
  rcpi_entry_s a_wdata;
  rcpi_entry_s a_rdata;

  // Memory port B controls
  // Slot after the unchannelised override
  logic [4:0] b_slot;
  logic [9:0] b_addr;
  rcpi_entry_s b_rdata;

  // Decoded host strokes
  logic sel_wr;
  logic data_wr;
  logic sel_rd;
  logic data_rd;

  // Select write accepted only while idle
  logic trigger;

  // Fields carried by a host write
  logic [4:0] wr_link;
  logic [4:0] wr_slot;
  logic wr_dir;
  rcpi_entry_s wr_entry;

  // Read words as the host sees them
  logic [31:0] sel_word;
  logic [31:0] data_word;

  // Address decode of the two registers
  // Exact match on the byte address; other offsets fall through
  always_comb begin
    sel_wr = REG_WR && (REG_ADDR == `RCPI_SEL_OFF);
    data_wr = REG_WR && (REG_ADDR == `RCPI_DATA_OFF);
    sel_rd = REG_RD && (REG_ADDR == `RCPI_SEL_OFF);
    data_rd = REG_RD && (REG_ADDR == `RCPI_DATA_OFF);
  end

  // A select write while busy is dropped whole, so the fields
  // of the access under way keep their values
  always_comb begin
    trigger = sel_wr && (s_r.state == ST_IDLE);
  end

  // Unpack the write word once; both registers share the bus
  always_comb begin
    wr_link = REG_WDATA[`RCPI_LINK_MSB:`RCPI_LINK_LSB];
    wr_slot = REG_WDATA[`RCPI_SLOT_MSB:`RCPI_SLOT_LSB];
    wr_dir = REG_WDATA[`RCPI_DIR_BIT];
    // Entry fields in data register order
    wr_entry.channel_number_field = REG_WDATA[`RCPI_CHANNEL_NUMBER_FIELD_MSB:`RCPI_CHANNEL_NUMBER_FIELD_LSB];
    wr_entry.provision_flag = REG_WDATA[`RCPI_PROVISION_FLAG_BIT];
    wr_entry.lb = REG_WDATA[`RCPI_LB_BIT];
  end

  // Read words; unused bits read zero so software may mask less
  always_comb begin
    sel_word = 32'h0000_0000;
    sel_word[`RCPI_BUSY_BIT] = s_r.busy;
    sel_word[`RCPI_DIR_BIT] = s_r.dir;
    sel_word[`RCPI_LINK_MSB:`RCPI_LINK_LSB] = s_r.link;
    sel_word[`RCPI_SLOT_MSB:`RCPI_SLOT_LSB] = s_r.slot;
    // Data word
    data_word = 32'h0000_0000;
    data_word[`RCPI_LB_BIT] = s_r.data.lb;
    data_word[`RCPI_PROVISION_FLAG_BIT] = s_r.data.provision_flag;
    data_word[`RCPI_CHANNEL_NUMBER_FIELD_MSB:`RCPI_CHANNEL_NUMBER_FIELD_LSB] = s_r.data.channel_number_field;
  end

  // Port A is driven only from registered state, so a late
  // host write cannot disturb an access under way
  always_comb begin
    // Enabled only in the access state; idle costs no reads
    a_en = (s_r.state == ST_ACCESS);
    a_we = (s_r.state == ST_ACCESS) && (s_r.dir == `RCPI_DIR_WRITE);
    a_addr = {s_r.slot, s_r.link};
    // Entry to store is the staged data register
    a_wdata = s_r.data;
  end

  // Lookup address for the incoming byte
  // Unchannelised links keep one entry per link, at slot zero,
  // whatever slot number arrives with the byte
  always_comb begin
    b_slot = CHANNELISE_ENABLE[RX_LINK] ? RX_SLOT : `RCPI_SLOT_UNCH;
    b_addr = {b_slot, RX_LINK};
  end

  // Next-state logic: registers, sequencer, read data
  always_comb begin
    // Hold everything unless a branch below says otherwise
    s_nxt = s_r;
    // Answer pulse lasts one cycle
    s_nxt.rack = 1'b0;

    // Sequencer. Edges after the select write is taken:
    //   write access: edge 1 stores the entry, busy falls
    //   read access: edge 1 reads memory, edge 2 captures it
    // Fields latched at the trigger stay put until busy falls,
    // so software never sees a half-done access.
    case (s_r.state)
      ST_IDLE: begin
        if (trigger) begin
          // Latch the access; these fields stay put until done
          s_nxt.link = wr_link;
          s_nxt.slot = wr_slot;
          s_nxt.dir = wr_dir;
          s_nxt.busy = 1'b1;
          s_nxt.state = ST_ACCESS;
        end
      end
      ST_ACCESS: begin
        // Write finishes here; a read needs one more cycle
        if (s_r.dir == `RCPI_DIR_READ) begin
          // Memory data lands at the end of this cycle
          s_nxt.state = ST_CAPTURE;
        end else begin
          s_nxt.busy = 1'b0;
          s_nxt.state = ST_IDLE;
        end
      end
      ST_CAPTURE: begin
        // Data register takes the entry at this edge
        // busy falls when done
        s_nxt.busy = 1'b0;
        s_nxt.state = ST_IDLE;
      end
      default: begin
        // Recover from an illegal code
        s_nxt.busy = 1'b0;
        s_nxt.state = ST_IDLE;
      end
    endcase

    if (data_wr) begin
      // Software may stage the next entry at any time outside a read access
      s_nxt.data = wr_entry;
    end

    if (s_r.state == ST_CAPTURE) begin
      // Memory wins over a host write in the same cycle
      s_nxt.data = a_rdata;
    end

    // Registered read answer
    // Reads have no side effects on either register
    if (sel_rd) begin
      s_nxt.rdata = sel_word;
      s_nxt.rack = 1'b1;
    end else if (data_rd) begin
      s_nxt.rdata = data_word;
      s_nxt.rack = 1'b1;
    end else if (REG_RD) begin
      // Unmapped offset answers zero
      s_nxt.rdata = 32'h0000_0000;
      s_nxt.rack = 1'b1;
    end
  end

  // State register, synchronous reset
  always_ff @(posedge REF_CLK) begin
    // Memory contents are not reset; only the sequencer and the
    // registers around it return to known values
    if (!RST_N) begin
      // Sequencer idle, no access pending
      s_r.state <= ST_IDLE;
      s_r.busy <= 1'b0;
      // Fields of the last access
      s_r.dir <= `RCPI_DIR_RST;
      s_r.link <= `RCPI_LINK_RST;
      s_r.slot <= `RCPI_SLOT_RST;
      // Staged entry in the data register
      s_r.data.channel_number_field <= `RCPI_CHANNEL_NUMBER_FIELD_RST;
      s_r.data.provision_flag <= `RCPI_PROVISION_FLAG_RST;
      s_r.data.lb <= `RCPI_LB_RST;
      // Read port quiet
      s_r.rdata <= 32'h0000_0000;
      s_r.rack <= 1'b0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Provision memory, 32 links by 32 slots
  // Port A belongs to the sequencer, port B to the byte path;
  // a write and a lookup of one entry on one edge give the old entry
  // Entry width: loopback, provision, seven-bit channel
  rcpi_provision_flag_mem #(
    .AW(10),
    .DW(9)
  ) u_mem (
    .clk(REF_CLK),
    .a_en(a_en),
    .a_we(a_we),
    .a_addr(a_addr),
    .a_wdata(a_wdata),
    .a_rdata(a_rdata),
    .b_en(RX_VALID),
    .b_addr(b_addr),
    .b_rdata(b_rdata)
  );

  // Byte lookup pipeline; its outputs are flip-flops
  // Bytes may come every cycle; each one gets its verdict
  // LB_DATA must already show the FIFO head while LB_POP is high
  rcpi_byte_path u_path (
    .clk(REF_CLK),
    .rst_n(RST_N),
    .entry(b_rdata),
    .in_valid(RX_VALID),
    .in_data(RX_DATA),
    .lb_data(LB_DATA),
    .lb_pop(LB_POP),
    .lb_channel_number_field(LB_CHANNEL_NUMBER_FIELD),
    .out_valid(OUT_VALID),
    .out_channel_number_field(OUT_CHANNEL_NUMBER_FIELD),
    .out_data(OUT_DATA),
    .out_drop(OUT_DROP)
  );

  // Register port outputs straight from state
  // Both come from flip-flops, so the host sees no glitches
  assign REG_RDATA = s_r.rdata;
  assign REG_RACK = s_r.rack;

endmodule
`default_nettype wire

// >>> rcpi_checker.sv
`timescale 1ns/1ns
`default_nettype none
`include "rcpi_defs.svh"
// Port-level checks for the provision block
module rcpi_checker (
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic RST_N,
  // Register port
  input wire logic [11:0] REG_ADDR,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [31:0] REG_RDATA,
  input wire logic REG_RACK,
  // Byte path
  input wire logic RX_VALID,
  input wire logic [7:0] LB_DATA,
  input wire logic LB_POP,
  input wire logic [6:0] LB_CHANNEL_NUMBER_FIELD,
  input wire logic OUT_VALID,
  input wire logic [6:0] OUT_CHANNEL_NUMBER_FIELD,
  input wire logic [7:0] OUT_DATA,
  input wire logic OUT_DROP
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);
  // Answer exactly one cycle after a read
  property p_rack; REG_RD |=> REG_RACK; endproperty
  property p_norack; !REG_RD |=> !REG_RACK; endproperty
  // Select writes seen on the port
  logic sel_wr_seen;
  assign sel_wr_seen = REG_WR && (REG_ADDR == `RCPI_SEL_OFF);
  // Busy seen by a read right after a trigger taken while idle;
  // no select write on the two edges before means none in flight
  property p_busy;
    (sel_wr_seen && !$past(sel_wr_seen) && !$past(sel_wr_seen, 2))
      ##1 (REG_RD && REG_ADDR == `RCPI_SEL_OFF) |=> REG_RDATA[`RCPI_BUSY_BIT];
  endproperty
  // Read data holds between answers
  property p_hold; !REG_RACK |-> $stable(REG_RDATA); endproperty
  // Every byte gets a verdict at a fixed latency
  property p_resp; RX_VALID |-> (##2 OUT_DROP) or (##3 OUT_VALID); endproperty
  property p_src; OUT_VALID |-> $past(RX_VALID, 3); endproperty
  property p_excl; OUT_DROP |-> !LB_POP; endproperty
  // Popped byte replaces the received one
  property p_pop;
    LB_POP |=> OUT_VALID && OUT_DATA == $past(LB_DATA) && OUT_CHANNEL_NUMBER_FIELD == $past(LB_CHANNEL_NUMBER_FIELD);
  endproperty
  a_rack: assert property (p_rack)
    else $error("read not answered");
  a_norack: assert property (p_norack)
    else $error("stray read answer");
  a_busy: assert property (p_busy)
    else $error("busy not set after trigger");
  a_hold: assert property (p_hold)
    else $error("read data moved");
  a_resp: assert property (p_resp)
    else $error("byte without verdict");
  a_src: assert property (p_src)
    else $error("output without byte");
  a_excl: assert property (p_excl)
    else $error("drop and pop together");
  a_pop: assert property (p_pop)
    else $error("loopback byte not substituted");
  // Main scenarios reached
  c_pop: cover property (LB_POP);
  c_drop: cover property (OUT_DROP);
  c_busy: cover property (REG_RACK && REG_RDATA[15]);
endmodule
bind rcpi_top rcpi_checker u_chk (.REF_CLK, .RST_N, .REG_ADDR, .REG_WR, .REG_RD,
  .REG_RDATA, .REG_RACK, .RX_VALID, .LB_DATA, .LB_POP, .LB_CHANNEL_NUMBER_FIELD, .OUT_VALID,
  .OUT_CHANNEL_NUMBER_FIELD, .OUT_DATA, .OUT_DROP);
`default_nettype wire

// >>> test_rcpi_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "rcpi_defs.svh"
module test_rcpi_top;
  // Design ports
  logic REF_CLK, RST_N, REG_WR, REG_RD, REG_RACK, RX_VALID;
  logic LB_POP, OUT_VALID, OUT_DROP;
  logic [11:0] REG_ADDR;
  logic [31:0] REG_WDATA, REG_RDATA, CHANNELISE_ENABLE;
  logic [4:0] RX_LINK, RX_SLOT;
  logic [7:0] RX_DATA, LB_DATA, OUT_DATA;
  logic [6:0] LB_CHANNEL_NUMBER_FIELD, OUT_CHANNEL_NUMBER_FIELD;
  // Tallies and last read word
  int num_errors = 0;
  int total_checks = 0;
  logic [31:0] v;

  rcpi_top u_dut (.REF_CLK, .RST_N, .REG_ADDR, .REG_WR, .REG_RD, .REG_WDATA,
    .REG_RDATA, .REG_RACK, .CHANNELISE_ENABLE, .RX_VALID, .RX_LINK, .RX_SLOT,
    .RX_DATA, .LB_DATA, .LB_POP, .LB_CHANNEL_NUMBER_FIELD, .OUT_VALID, .OUT_CHANNEL_NUMBER_FIELD, .OUT_DATA,
    .OUT_DROP);

  // 4 ns clock
  initial begin
    REF_CLK = 0;
    forever #2 REF_CLK = ~REF_CLK;
  end

  // Step past edges; 1 ns keeps drives off the edge
  task automatic cyc(input int n);
    repeat (n) @(posedge REF_CLK);
    #1;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value at %0t: got %h exp %h", $time, g, e);
    end
  endtask

  // Gap after each strobe so it never toggles twice in one step
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    REG_ADDR = a;
    REG_WDATA = d;
    REG_WR = 1;
    cyc(1);
    REG_WR = 0;
    cyc(1);
  endtask

  task automatic rd(input logic [11:0] a);
    REG_ADDR = a;
    REG_RD = 1;
    cyc(1);
    REG_RD = 0;
    chk(REG_RACK, 1);
    v = REG_RDATA;
    cyc(1);
  endtask

  // Bounded busy poll
  task automatic poll;
    int k = 0;
    do begin
      rd(`RCPI_SEL_OFF);
      k++;
    end while (v[15] !== 1'b0 && k < 10);
    chk(v[15], 0);
  endtask

  // Indirect access: e is {loopback, provision, 0, channel}
  task automatic ent(input logic d, input logic [4:0] l, s, input logic [9:0] e);
    if (!d) wr(`RCPI_DATA_OFF, {22'h0, e});
    wr(`RCPI_SEL_OFF, {17'h0, d, 1'b0, l, 3'h0, s});
    poll;
  endtask

  task automatic t_reset;
    rd(`RCPI_SEL_OFF);
    chk(v, 0);
    rd(`RCPI_DATA_OFF);
    chk(v, 0);
    rd(12'h108);
    chk(v, 0);
    $display("test reset done");
  endtask

  task automatic t_ind;
    ent(0, 31, 5, 10'h155);
    ent(0, 0, 31, 10'h22A);
    rd(`RCPI_DATA_OFF);
    chk(v, 32'h22A);
    ent(1, 31, 5, 0);
    rd(`RCPI_DATA_OFF);
    chk(v, 32'h155);
    rd(`RCPI_SEL_OFF);
    chk(v, 32'h5F05);
    ent(1, 0, 31, 0);
    rd(`RCPI_DATA_OFF);
    chk(v, 32'h22A);
    $display("test indirect done");
  endtask

  // Second trigger lands while the first read is in flight
  task automatic t_busy;
    REG_ADDR = `RCPI_SEL_OFF;
    REG_WDATA = 32'h5F05;
    REG_WR = 1;
    cyc(1);
    // Retrigger and busy read share the next edge
    REG_WDATA = 32'h001F;
    REG_RD = 1;
    cyc(1);
    REG_WR = 0;
    REG_RD = 0;
    chk(REG_RDATA, 32'hDF05);
    cyc(1);
    poll;
    rd(`RCPI_SEL_OFF);
    chk(v, 32'h5F05);
    ent(1, 0, 31, 0);
    rd(`RCPI_DATA_OFF);
    chk(v, 32'h22A);
    $display("test busy done");
  endtask

  // One byte; k 0 = pass, 1 = drop, 2 = loopback
  task automatic bt(input logic [4:0] l, s, input logic [7:0] d, input int k,
      input logic [6:0] c, input logic [7:0] o);
    RX_LINK = l;
    RX_SLOT = s;
    RX_DATA = d;
    RX_VALID = 1;
    cyc(1);
    RX_VALID = 0;
    // Drop and pop stand for one cycle, one edge after the byte
    cyc(1);
    chk(OUT_DROP, k == 1);
    chk(LB_POP, k == 2);
    if (k == 2) chk(LB_CHANNEL_NUMBER_FIELD, c);
    cyc(1);
    chk(OUT_VALID, k != 1);
    if (k != 1) chk({OUT_CHANNEL_NUMBER_FIELD, OUT_DATA}, {c, o});
  endtask

  task automatic t_bytes;
    ent(0, 1, 2, 10'h111);
    ent(0, 1, 3, 10'h012);
    ent(0, 1, 4, 10'h322);
    ent(0, 2, 0, 10'h133);
    ent(0, 2, 9, 10'h144);
    CHANNELISE_ENABLE = 32'h2;
    LB_DATA = 8'hC3;
    bt(1, 2, 8'hA5, 0, 7'h11, 8'hA5);
    bt(1, 3, 8'h5A, 1, 0, 0);
    bt(1, 4, 8'h3C, 2, 7'h22, 8'hC3);
    bt(2, 9, 8'h77, 0, 7'h33, 8'h77);
    CHANNELISE_ENABLE = 32'h6;
    bt(2, 9, 8'h66, 0, 7'h44, 8'h66);
    $display("test bytes done");
  endtask

  task automatic summarize;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Watchdog, far beyond the hundred or so cycles needed
  initial begin
    #50000;
    num_errors++;
    summarize;
  end

  initial begin
    RST_N = 0;
    REG_ADDR = 0;
    REG_WR = 0;
    REG_RD = 0;
    REG_WDATA = 0;
    CHANNELISE_ENABLE = 0;
    RX_VALID = 0;
    RX_LINK = 0;
    RX_SLOT = 0;
    RX_DATA = 0;
    LB_DATA = 0;
    cyc(10);
    RST_N = 1;
    cyc(1);
    t_reset;
    t_ind;
    t_busy;
    t_bytes;
    summarize;
  end
endmodule
`default_nettype wire
